/* File: hdl/lsa_annunciator.sv */
`timescale 1ns/1ps
`default_nettype none
//Behaviour
// - power lamp steady when supply healthy and no board fault
// - ready lamp steady with permit, no fault
// - pass tickle and PWM only with permit
// - emission lamp on qualifying PWM, not tickle
// - first interface normal levels follow state
// - no permit: ready, emission dark, interface A and rf outputs low
// - over-temperature: ready flashes, overtemp output high
// - supply fault: power blinks, supply_fault_out high
// - board fault: both flash, interface A low
// - second interface health outputs high normally
// - second interface drops per fault type
// - fault code repeats with pause, latched
// - blink count per supply fault kind
// - permit loss does not latch
module lsa_annunciator import lsa_pkg::*; #(
	parameter int PAUSE_CYCLES = PAUSE_CYC,
	parameter int BLINK_CYCLES = BLINK_CYC,
	parameter int HOLD_CYCLES = EMIT_HOLD_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic irq,
	// controller and sensor pins
	input wire lsa_pins_t pins,
	// rf driver
	output logic rf_tickle,
	output logic rf_pwm,
	// lamps
	output logic supply_lamp,
	output logic ready_lamp,
	output logic emission_lamp,
	// status interfaces
	output lsa_ifa_t ifa,
	output lsa_ifb_t ifb
);
	lsa_pins_t sync1_q;
	lsa_pins_t pin_s;
	lsa_faults_t flt_q;
	logic [15:0] pwm_min_q;
	logic [15:0] pw_cnt_q;
	logic [31:0] hold_q;
	logic emit_q;
	logic permit_d1_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_evt;
	logic any_flt;
	logic dc_eff;
	logic ot_eff;
	logic gate;
	logic ready_ok;
	logic qual;
	lsa_lamp_req_t sup_req;
	lsa_lamp_req_t rdy_req;
	logic sup_blink;
	logic rdy_blink;
	logic setup;
	logic wr_en;
	logic [3:0] sel;

	if (HOLD_CYCLES < 1 || PAUSE_CYCLES < 1 || BLINK_CYCLES < 1) begin : g_chk
		$error("lsa_annunciator: counts must be at least one");
	end

	// pin synchroniser
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= '0;
			pin_s <= '0;
		end else begin
			sync1_q <= pins;
			pin_s <= sync1_q;
		end
	end

	// fault latches, cleared only by reset
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flt_q <= '0;
		end else begin
			if (pin_s.over_temp) begin
				flt_q.ot <= 1'b1;
			end
			if (pin_s.board) begin
				flt_q.bd <= 1'b1;
			end
			if (!flt_q.dc) begin
				if (pin_s.dc_sense) begin
					flt_q.dc <= 1'b1;
					flt_q.code <= CODE_SENSE;
				end else if (pin_s.over_volt) begin
					flt_q.dc <= 1'b1;
					flt_q.code <= CODE_OVER;
				end else if (pin_s.under_volt) begin
					flt_q.dc <= 1'b1;
					flt_q.code <= CODE_UNDER;
				end
			end
		end
	end

	assign any_flt = flt_q.ot || flt_q.dc || flt_q.bd;
	assign dc_eff = flt_q.dc && !flt_q.bd;
	assign ot_eff = flt_q.ot && !flt_q.dc && !flt_q.bd;
	assign ready_ok = pin_s.permit && !any_flt;
	assign gate = ready_ok;
	assign qual = gate && pin_s.pwm && ({1'b0, pw_cnt_q} + 17'h00001 >= {1'b0, pwm_min_q});

	// lamp requests
	always_comb begin
		sup_req = '{mode: LSA_STEADY, count: 2'h0};
		if (flt_q.bd) begin
			sup_req = '{mode: LSA_FLASH, count: 2'h0};
		end else if (flt_q.dc) begin
			sup_req = '{mode: LSA_CODE, count: flt_q.code};
		end
		rdy_req = '{mode: LSA_DARK, count: 2'h0};
		if (flt_q.bd || ot_eff) begin
			rdy_req = '{mode: LSA_FLASH, count: 2'h0};
		end else if (ready_ok) begin
			rdy_req = '{mode: LSA_STEADY, count: 2'h0};
		end
	end

	lsa_blink #(
		.ON_CYC(BLINK_CYCLES),
		.GAP_CYC(PAUSE_CYCLES)
	) u_sup_blink (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.req(sup_req),
		.lamp(sup_blink)
	);

	lsa_blink #(
		.ON_CYC(BLINK_CYCLES),
		.GAP_CYC(PAUSE_CYCLES)
	) u_rdy_blink (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.req(rdy_req),
		.lamp(rdy_blink)
	);

	// rf gating
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rf_tickle <= 1'b0;
			rf_pwm <= 1'b0;
		end else begin
			rf_tickle <= gate && pin_s.tickle;
			rf_pwm <= gate && pin_s.pwm;
		end
	end

	// emission detect: pulse must reach the programmed width
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pw_cnt_q <= 16'h0000;
			hold_q <= 32'h00000000;
			emit_q <= 1'b0;
		end else begin
			if (gate && pin_s.pwm && pw_cnt_q != 16'hFFFF) begin
				pw_cnt_q <= pw_cnt_q + 16'h0001;
			end else if (!(gate && pin_s.pwm)) begin
				pw_cnt_q <= 16'h0000;
			end
			if (!gate) begin
				emit_q <= 1'b0;
				hold_q <= 32'h00000000;
			end else if (qual) begin
				emit_q <= 1'b1;
				hold_q <= 32'(HOLD_CYCLES);
			end else if (hold_q != 32'h00000000) begin
				hold_q <= hold_q - 32'h00000001;
			end else begin
				emit_q <= 1'b0;
			end
		end
	end

	// lamps and status interfaces
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			supply_lamp <= 1'b0;
			ready_lamp <= 1'b0;
			emission_lamp <= 1'b0;
			ifa <= '0;
			ifb <= '0;
		end else begin
			supply_lamp <= sup_blink;
			ready_lamp <= rdy_blink;
			emission_lamp <= emit_q && gate;
			ifa.emission <= emit_q && gate;
			ifa.ready <= ready_ok;
			ifa.over_temp <= ot_eff;
			ifa.supply_fault_out <= dc_eff;
			ifb.unit_ok <= ready_ok;
			ifb.temp_ok <= !ot_eff;
			ifb.volt_ok <= !dc_eff;
		end
	end

	// events
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			permit_d1_q <= 1'b0;
		end else begin
			permit_d1_q <= pin_s.permit;
		end
	end

	always_comb begin
		irq_evt = '0;
		irq_evt[IRQ_OT] = pin_s.over_temp && !flt_q.ot;
		irq_evt[IRQ_DC] = (pin_s.dc_sense || pin_s.over_volt || pin_s.under_volt) && !flt_q.dc;
		irq_evt[IRQ_BD] = pin_s.board && !flt_q.bd;
		irq_evt[IRQ_PERMIT_LOSS] = permit_d1_q && !pin_s.permit;
		irq_evt[IRQ_EMIT] = qual && !emit_q;
	end

	// register select from a byte address, one bit per register
	function automatic logic [3:0] reg_hit(input logic [AW-1:0] a);
		reg_hit = 4'h0;
		if (a == ADDR_CTRL) begin
			reg_hit[0] = 1'b1;
		end else if (a == ADDR_STATE) begin
			reg_hit[1] = 1'b1;
		end else if (a == ADDR_IRQ_STAT) begin
			reg_hit[2] = 1'b1;
		end else if (a == ADDR_IRQ_MASK) begin
			reg_hit[3] = 1'b1;
		end
	endfunction : reg_hit

	// apb slave, answers in the access cycle
	assign sel = reg_hit(paddr);
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (setup) begin
				if (sel[0]) begin
					prdata <= {16'h0000, pwm_min_q};
				end else if (sel[1]) begin
					prdata[ST_OT] <= flt_q.ot;
					prdata[ST_DC] <= flt_q.dc;
					prdata[ST_BD] <= flt_q.bd;
					prdata[ST_PERMIT] <= pin_s.permit;
					prdata[ST_EMIT] <= emit_q;
					prdata[ST_CODE_LSB+1:ST_CODE_LSB] <= flt_q.code;
				end else if (sel[2]) begin
					prdata[IRQ_W-1:0] <= irq_stat_q;
				end else if (sel[3]) begin
					prdata[IRQ_W-1:0] <= irq_mask_q;
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwm_min_q <= PWM_MIN_RST;
			irq_mask_q <= IRQ_MASK_RST;
		end else if (wr_en) begin
			if (sel[0]) begin
				pwm_min_q <= pwdata[15:0];
			end else if (sel[3]) begin
				irq_mask_q <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// sticky status, set wins over write-one clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_q <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_en && sel[2]) begin
				irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_stat_q <= irq_stat_q | irq_evt;
			end
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	chk_rf_gate: assert property (rf_pwm || rf_tickle |-> $past(pin_s.permit))
		else $error("rf command passed without permit");
	chk_ready_on: assert property ((pin_s.permit && !any_flt) [*3] |-> ready_lamp && ifa.ready && ifb.unit_ok)
		else $error("ready lamp dark with permit and no fault");
	chk_no_permit: assert property ((!pin_s.permit && !any_flt) [*3] |-> !ready_lamp && !emission_lamp && ifa == '0)
		else $error("no permit but ready, emission or status set");
	chk_power_lamp: assert property ((!flt_q.dc && !flt_q.bd) [*4] |-> supply_lamp)
		else $error("power lamp not steady on healthy supply");
	chk_emit_cause: assert property ($rose(emission_lamp) |-> $past(pin_s.pwm, 2) && $past(gate))
		else $error("emission lamp lit without pwm");
	chk_ot_out: assert property (ot_eff |=> ifa.over_temp && !ifa.ready && !ifb.temp_ok && ifb.volt_ok)
		else $error("over-temperature outputs wrong");
	chk_dc_out: assert property (dc_eff |=> ifa == 4'h1 && !ifb.volt_ok && ifb.temp_ok)
		else $error("supply fault outputs wrong");
	chk_board_out: assert property (flt_q.bd |=> ifa == '0 && ifb.temp_ok && ifb.volt_ok)
		else $error("board fault outputs wrong");
	chk_fault_latch: assert property ($rose(flt_q.ot) |=> flt_q.ot [*8])
		else $error("fault latch released");
	chk_ifb_normal: assert property (!any_flt && pin_s.permit |=> ifb == 3'h7)
		else $error("second interface not healthy in normal state");
	chk_permit_back: assert property ($rose(pin_s.permit) && !any_flt |=> ifa.ready)
		else $error("permit return did not restore ready");
	chk_rf_fault: assert property (any_flt |=> !rf_pwm && !rf_tickle)
		else $error("rf command passed with latched fault");
	chk_emit_fault: assert property (any_flt |=> !emission_lamp && !ifa.emission)
		else $error("emission shown with latched fault");

	cov_emit: cover property (gate ##1 emission_lamp);
	cov_code_two: cover property (flt_q.dc && flt_q.code == CODE_OVER);
	cov_board: cover property (flt_q.bd ##1 supply_lamp);
	cov_irq: cover property ($rose(irq));
	cov_permit_loss: cover property ($fell(pin_s.permit) && !any_flt);
endmodule : lsa_annunciator
`default_nettype wire

/* File: common/lsa_pkg.sv */
`default_nettype none
package lsa_pkg;
	// clock and timing
	localparam int CLK_MHZ = 250;
	localparam int PAUSE_MS = 500;
	localparam int BLINK_MS = 250;
	localparam int EMIT_HOLD_US = 1000;
	localparam int PAUSE_CYC = PAUSE_MS * 1000 * CLK_MHZ;
	localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
	localparam int EMIT_HOLD_CYC = EMIT_HOLD_US * CLK_MHZ;
	// register map
	localparam int AW = 12;
	localparam logic [AW-1:0] ADDR_CTRL = 12'h000;
	localparam logic [AW-1:0] ADDR_STATE = 12'h004;
	localparam logic [AW-1:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [AW-1:0] ADDR_IRQ_MASK = 12'h00C;
	localparam logic [15:0] PWM_MIN_RST = 16'h01F4;
	// event bits
	localparam int IRQ_W = 5;
	localparam int IRQ_OT = 0;
	localparam int IRQ_DC = 1;
	localparam int IRQ_BD = 2;
	localparam int IRQ_PERMIT_LOSS = 3;
	localparam int IRQ_EMIT = 4;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
	// state register fields
	localparam int ST_OT = 0;
	localparam int ST_DC = 1;
	localparam int ST_BD = 2;
	localparam int ST_PERMIT = 3;
	localparam int ST_EMIT = 4;
	localparam int ST_CODE_LSB = 8;
	// supply fault codes
	localparam logic [1:0] CODE_UNDER = 2'h1;
	localparam logic [1:0] CODE_OVER = 2'h2;
	localparam logic [1:0] CODE_SENSE = 2'h3;

	typedef enum logic [1:0] {LSA_DARK, LSA_STEADY, LSA_CODE, LSA_FLASH} lsa_mode_t;

	typedef struct packed {
		lsa_mode_t mode;
		logic [1:0] count;
	} lsa_lamp_req_t;

	typedef struct packed {
		logic permit;
		logic tickle;
		logic pwm;
		logic over_temp;
		logic under_volt;
		logic over_volt;
		logic dc_sense;
		logic board;
	} lsa_pins_t;

	typedef struct packed {
		logic emission;
		logic ready;
		logic over_temp;
		logic supply_fault_out;
	} lsa_ifa_t;

	typedef struct packed {
		logic unit_ok;
		logic temp_ok;
		logic volt_ok;
	} lsa_ifb_t;

	typedef struct packed {
		logic ot;
		logic dc;
		logic bd;
		logic [1:0] code;
	} lsa_faults_t;
endpackage : lsa_pkg
`default_nettype wire

/* File: hdl/lsa_blink.sv */
`timescale 1ns/1ps
`default_nettype none
module lsa_blink import lsa_pkg::*; #(
	parameter int ON_CYC = BLINK_CYC,
	parameter int GAP_CYC = PAUSE_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// lamp request and drive
	input wire lsa_lamp_req_t req,
	output logic lamp
);
	typedef enum logic [1:0] {BL_ON, BL_OFF, BL_PAUSE} lsa_bl_state_t;

	lsa_bl_state_t st_q;
	logic [31:0] cnt_q;
	logic [1:0] n_q;
	logic blinking;
	logic last;

	if (ON_CYC < 1 || GAP_CYC < 1) begin : g_chk
		$error("lsa_blink: counts must be at least one");
	end

	assign blinking = (req.mode == LSA_CODE) || (req.mode == LSA_FLASH);
	assign last = (st_q == BL_PAUSE) ? (cnt_q == 32'(GAP_CYC - 1)) : (cnt_q == 32'(ON_CYC - 1));

	// code sequencer: n blinks, pause, repeat
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= BL_ON;
			cnt_q <= 32'h00000000;
			n_q <= 2'h0;
		end else if (!blinking) begin
			st_q <= BL_ON;
			cnt_q <= 32'h00000000;
			n_q <= 2'h0;
		end else if (!last) begin
			cnt_q <= cnt_q + 32'h00000001;
		end else begin
			cnt_q <= 32'h00000000;
			case (st_q)
				BL_ON: begin
					st_q <= BL_OFF;
				end
				BL_OFF: begin
					if (req.mode == LSA_FLASH) begin
						st_q <= BL_ON;
					end else if (n_q + 2'h1 >= req.count) begin
						st_q <= BL_PAUSE;
						n_q <= 2'h0;
					end else begin
						n_q <= n_q + 2'h1;
						st_q <= BL_ON;
					end
				end
				default: begin
					st_q <= BL_ON;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			lamp <= 1'b0;
		end else begin
			lamp <= (req.mode == LSA_STEADY) || (blinking && st_q == BL_ON);
		end
	end
endmodule : lsa_blink
`default_nettype wire

/* File: sim/lsa_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lsa_ctrl_model (
	// clock
	input wire logic core_clk,
	// commands from the bench
	input wire logic permit_cmd,
	input wire logic go,
	input wire logic sel_pwm,
	input wire logic [15:0] len,
	// controller pins toward the laser
	output logic permit,
	output logic tickle,
	output logic pwm
);
	logic [15:0] cnt_q = 16'h0000;
	logic permit_q = 1'b0;
	logic tickle_q = 1'b0;
	logic pwm_q = 1'b0;
	// one pulse of len cycles per request, lines low between pulses
	always @(posedge core_clk) begin
		permit_q <= permit_cmd;
		if (cnt_q != 16'h0000) begin
			cnt_q <= cnt_q - 16'h0001;
			if (cnt_q == 16'h0001) begin
				tickle_q <= 1'b0;
				pwm_q <= 1'b0;
			end
		end else if (go) begin
			cnt_q <= len;
			tickle_q <= !sel_pwm;
			pwm_q <= sel_pwm;
		end
	end
	assign permit = permit_q;
	assign tickle = tickle_q;
	assign pwm = pwm_q;
endmodule : lsa_ctrl_model
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb import lsa_pkg::*;;
	logic core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic go = 1'b0, sel_pwm = 1'b0, permit_cmd = 1'b0, err, l, p;
	logic [AW-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
	logic [15:0] plen = 16'h0000;
	logic [4:0] flt = 5'h00;
	logic [3:0] seen;
	logic pready, pslverr, irq, rf_tickle, rf_pwm, supply_lamp, ready_lamp, emission_lamp;
	logic m_permit, m_tkl, m_pwm;
	lsa_ifa_t ifa;
	lsa_ifb_t ifb;
	lsa_pins_t pins;
	int n_fail = 0, cmp_count = 0, mp, mo, md, mb, n;
	assign pins = {m_permit, m_tkl, m_pwm, flt};

	lsa_ctrl_model ctrl (.core_clk(core_clk), .permit_cmd(permit_cmd), .go(go), .sel_pwm(sel_pwm),
		.len(plen), .permit(m_permit), .tickle(m_tkl), .pwm(m_pwm));
	lsa_annunciator #(.PAUSE_CYCLES(20), .BLINK_CYCLES(5), .HOLD_CYCLES(10)) DUT (.core_clk(core_clk),
		.arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq), .pins(pins), .rf_tickle(rf_tickle),
		.rf_pwm(rf_pwm), .supply_lamp(supply_lamp), .ready_lamp(ready_lamp), .emission_lamp(emission_lamp),
		.ifa(ifa), .ifb(ifb));

	initial begin
		forever #2 core_clk = ~core_clk;
	end

	task tick(input int c);
		repeat (c) @(posedge core_clk);
	endtask : tick

	task chk(input logic [31:0] got, input logic [31:0] want);
		cmp_count++;
		if (got !== want) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask : chk

	task give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	task apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// expected status levels from the model state
	function logic [3:0] e_ifa();
		if (mb != 0) return 4'h0;
		if (md != 0) return 4'h1;
		if (mo != 0) return 4'h2;
		return {1'b0, mp[0], 2'h0};
	endfunction : e_ifa

	function logic [2:0] e_ifb();
		if (mb != 0) return 3'h3;
		if (md != 0) return 3'h2;
		if (mo != 0) return 3'h1;
		return {mp[0], 2'h3};
	endfunction : e_ifb

	task check_state;
		chk(ifa, e_ifa());
		chk(ifb, e_ifb());
		chk(emission_lamp, 0);
		if (mo == 0 && md == 0 && mb == 0) begin
			chk(ready_lamp, mp);
			chk(supply_lamp, 1);
		end
	endtask : check_state

	task do_reset;
		arst_n <= 1'b0;
		flt <= 5'h00;
		permit_cmd <= 1'b0;
		tick(6);
		arst_n <= 1'b1;
		mp = 0;
		mo = 0;
		md = 0;
		mb = 0;
		tick(8);
	endtask : do_reset

	task set_permit(input logic v);
		permit_cmd <= v;
		mp = v;
		tick(7);
	endtask : set_permit

	task fault(input int b);
		flt <= 5'h01 << b;
		tick(4);
		flt <= 5'h00;
		tick(8);
	endtask : fault

	// seen = {rf_tickle, rf_pwm, ifa.emission, emission_lamp}, or-ed over the pulse
	task pulse(input logic sp, input int len);
		seen = 4'h0;
		go <= 1'b1;
		sel_pwm <= sp;
		plen <= len[15:0];
		@(posedge core_clk);
		go <= 1'b0;
		repeat (len + 6) begin
			@(posedge core_clk);
			seen = seen | {rf_tickle, rf_pwm, ifa.emission, emission_lamp};
		end
	endtask : pulse

	task rises(input logic which, input int c);
		n = 0;
		p = 1'b1;
		repeat (c) begin
			@(posedge core_clk);
			l = which ? ready_lamp : supply_lamp;
			if (l && !p) n++;
			p = l;
		end
	endtask : rises

	// blinks of the supply lamp inside one code group
	task grp;
		int run, k;
		n = 0;
		run = 0;
		k = 0;
		while (run < 15 && k < 300) begin
			@(posedge core_clk);
			k++;
			run = supply_lamp ? 0 : run + 1;
		end
		run = 0;
		p = 1'b0;
		while (run < 15 && k < 300) begin
			@(posedge core_clk);
			k++;
			if (supply_lamp && !p) n++;
			p = supply_lamp;
			run = supply_lamp ? 0 : run + 1;
		end
	endtask : grp

	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		give_verdict;
	end

	initial begin
		void'($urandom(72177));
		do_reset;
		check_state;
		rises(0, 40);
		chk(n, 0);
		pulse(1'b0, 4);
		chk(seen, 4'h0);
		apb(1'b0, ADDR_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_01F4);
		apb(1'b1, ADDR_CTRL, 32'h0000_0008);
		apb(1'b0, ADDR_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0008);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk(err, 1);
		chk(rd, 32'h0000_0000);
		set_permit(1'b1);
		check_state;
		repeat (3) begin
			pulse(1'b0, 2 + int'($urandom % 4));
			chk(seen, 4'h8);
		end
		repeat (3) begin
			pulse(1'b1, 10 + int'($urandom % 10));
			chk(seen, 4'h7);
		end
		tick(20);
		check_state;
		set_permit(1'b0);
		check_state;
		chk(irq, 0);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0008);
		tick(2);
		chk(irq, 1);
		apb(1'b0, ADDR_IRQ_MASK, 32'h0000_0000);
		chk(rd, 32'h0000_0008);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0000_0000);
		chk(rd, 32'h0000_0018);
		set_permit(1'b1);
		check_state;
		pulse(1'b1, 12);
		chk(seen, 4'h7);
		apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0008);
		tick(2);
		chk(irq, 0);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0000_0000);
		chk(rd, 32'h0000_0010);
		do_reset;
		set_permit(1'b1);
		fault(4);
		mo = 1;
		check_state;
		rises(1, 40);
		chk(n, 4);
		chk(supply_lamp, 1);
		pulse(1'b1, 20);
		chk(seen, 4'h0);
		for (int i = 1; i < 4; i++) begin
			do_reset;
			set_permit(1'b1);
			fault(4 - i);
			md = 1;
			check_state;
			chk(ready_lamp, 0);
			apb(1'b0, ADDR_STATE, 32'h0000_0000);
			chk(rd[9:8], i);
			grp;
			chk(n, i);
			apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0002);
			tick(2);
			chk(irq, 1);
			apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0002);
			tick(2);
			chk(irq, 0);
		end
		do_reset;
		set_permit(1'b1);
		fault(0);
		mb = 1;
		check_state;
		rises(1, 40);
		chk(n, 4);
		rises(0, 40);
		chk(n, 4);
		give_verdict;
	end
endmodule : tb
`default_nettype wire
